//--- rtl/cdc_top.sv
// comparator digital control: registers, flags, interrupt request
// assumes an 8-bit register bus in the clk_sys domain and digitised
// comparator inputs from the analog front end
`timescale 1ns/1ps
`default_nettype none
module cdc_top
  import cdc_pkg::*;
(
  input wire logic clk_sys, // system clock, 200 MHz
  input wire logic resetn, // asynchronous reset, active low
  input wire logic clk_en, // clock enable, freezes all state
  input wire logic [CDC_IN_W-1:0] positive_input, // positive side, mV
  input wire logic [CDC_IN_W-1:0] negative_input, // negative side, mV
  input wire logic [7:0] sfr_addr, // register address
  input wire logic [7:0] sfr_wdata, // write data
  input wire logic sfr_wr, // write strobe, one cycle
  input wire logic sfr_rd, // read strobe, one cycle
  output logic [7:0] sfr_rdata, // read data, one cycle after strobe
  input wire logic irq_source_enable, // comparator enabled as source
  input wire logic irq_global_enable, // global interrupt enable
  output logic comparator_irq_req, // flag and enable request
  output logic cpu_irq_req, // request gated to the processor
  output logic latched_output, // synchronised compare result
  output logic raw_output, // unsynchronised compare result
  output logic comparator_shutdown, // analog low-power shutdown
  output logic [1:0] response_mode_select, // analog response mode
  output logic [1:0] positive_hysteresis_select, // analog hyst up
  output logic [1:0] negative_hysteresis_select // analog hyst down
);

  // control register state
  logic enable_q;
  logic enable_d;
  logic rise_flag_q;
  logic rise_flag_d;
  logic fall_flag_q;
  logic fall_flag_d;
  logic [1:0] hyp_q;
  logic [1:0] hyp_d;
  logic [1:0] hyn_q;
  logic [1:0] hyn_d;

  // mode register state
  logic rise_irq_enable_q;
  logic rise_irq_enable_d;
  logic fall_irq_enable_q;
  logic fall_irq_enable_d;
  logic [1:0] mode_q;
  logic [1:0] mode_d;

  // read data register
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  // decoded strobes and read images
  logic hit_ctrl;
  logic hit_mode;
  logic wr_ctrl;
  logic wr_mode;
  logic [7:0] ctrl_image;
  logic [7:0] mode_image;
  logic [7:0] read_mux;

  cdc_cmp_if link ();

  // settings handed to the compare path
  assign link.enable = enable_q;
  assign link.hyp_sel = hyp_q;
  assign link.hyn_sel = hyn_q;

  // combinational compare keeps raw alive without a clock
  cdc_compare u_compare (
    .positive_input(positive_input),
    .negative_input(negative_input),
    .cmp(link.cmp)
  );

  // synchroniser and edge detector on clk_sys
  cdc_sync_edge u_sync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .clk_en(clk_en),
    .syn(link.syn)
  );

  // address decode, unmapped addresses read zero and ignore writes
  assign hit_ctrl = sfr_addr == CDC_ADDR_CTRL;
  assign hit_mode = sfr_addr == CDC_ADDR_MODE;
  assign wr_ctrl = sfr_wr & hit_ctrl;
  assign wr_mode = sfr_wr & hit_mode;

  // control register next values
  assign enable_d = wr_ctrl ? sfr_wdata[CDC_CTRL_EN_BIT] : enable_q;
  assign hyp_d = wr_ctrl ?
    sfr_wdata[CDC_CTRL_HYP_LSB +: 2] : hyp_q;
  assign hyn_d = wr_ctrl ?
    sfr_wdata[CDC_CTRL_HYN_LSB +: 2] : hyn_q;

  // a detected edge wins over a same-cycle software clear
  assign rise_flag_d = link.rise_evt |
    (wr_ctrl ? sfr_wdata[CDC_CTRL_RISE_BIT] : rise_flag_q);
  assign fall_flag_d = link.fall_evt |
    (wr_ctrl ? sfr_wdata[CDC_CTRL_FALL_BIT] : fall_flag_q);

  // mode register next values, reserved bit not stored
  assign rise_irq_enable_d = wr_mode ?
    sfr_wdata[CDC_MODE_RIE_BIT] : rise_irq_enable_q;
  assign fall_irq_enable_d = wr_mode ?
    sfr_wdata[CDC_MODE_FIE_BIT] : fall_irq_enable_q;
  assign mode_d = wr_mode ?
    sfr_wdata[CDC_MODE_MD_LSB +: 2] : mode_q;

  // control and mode register flops
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      enable_q <= CDC_CTRL_RESET[CDC_CTRL_EN_BIT];
      rise_flag_q <= CDC_CTRL_RESET[CDC_CTRL_RISE_BIT];
      fall_flag_q <= CDC_CTRL_RESET[CDC_CTRL_FALL_BIT];
      hyp_q <= CDC_CTRL_RESET[CDC_CTRL_HYP_LSB +: 2];
      hyn_q <= CDC_CTRL_RESET[CDC_CTRL_HYN_LSB +: 2];
      rise_irq_enable_q <= CDC_MODE_RESET[CDC_MODE_RIE_BIT];
      fall_irq_enable_q <= CDC_MODE_RESET[CDC_MODE_FIE_BIT];
      mode_q <= CDC_MD_RESET;
    end else if (clk_en) begin
      enable_q <= enable_d;
      rise_flag_q <= rise_flag_d;
      fall_flag_q <= fall_flag_d;
      hyp_q <= hyp_d;
      hyn_q <= hyn_d;
      rise_irq_enable_q <= rise_irq_enable_d;
      fall_irq_enable_q <= fall_irq_enable_d;
      mode_q <= mode_d;
    end
  end

  // register read images
  assign ctrl_image = {enable_q, link.state, rise_flag_q, fall_flag_q,
    hyp_q, hyn_q};
  assign mode_image = {1'b1, 1'b0, rise_irq_enable_q, fall_irq_enable_q,
    2'h0, mode_q};
  assign read_mux = hit_ctrl ? ctrl_image :
    (hit_mode ? mode_image : 8'h00);
  assign rdata_d = sfr_rd ? read_mux : rdata_q;

  // read data held until the next read strobe
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 8'h00;
    end else if (clk_en) begin
      rdata_q <= rdata_d;
    end
  end

  assign sfr_rdata = rdata_q;

  // interrupt request from sticky flags and per-edge enables
  assign comparator_irq_req = (rise_flag_q & rise_irq_enable_q) |
    (fall_flag_q & fall_irq_enable_q);
  // the interrupt controller's gates decide if the cpu sees it
  assign cpu_irq_req = comparator_irq_req & irq_source_enable &
    irq_global_enable;

  // outputs towards the pins and analog front end
  assign latched_output = link.state;
  assign raw_output = link.raw;
  assign comparator_shutdown = ~enable_q;
  assign response_mode_select = mode_q;
  assign positive_hysteresis_select = hyp_q;
  assign negative_hysteresis_select = hyn_q;

endmodule
`default_nettype wire

//--- pkg/cdc_pkg.sv
// constants shared by the comparator digital control block
// assumes an 8-bit special function register bus at fixed addresses
package cdc_pkg;

  // register addresses on the special function register bus
  localparam logic [7:0] CDC_ADDR_CTRL = 8'h9B;
  localparam logic [7:0] CDC_ADDR_MODE = 8'h9D;

  // comparator control register fields
  localparam int CDC_CTRL_EN_BIT = 7;
  localparam int CDC_CTRL_OUT_BIT = 6;
  localparam int CDC_CTRL_RISE_BIT = 5;
  localparam int CDC_CTRL_FALL_BIT = 4;
  localparam int CDC_CTRL_HYP_LSB = 2;
  localparam int CDC_CTRL_HYN_LSB = 0;
  localparam logic [7:0] CDC_CTRL_RESET = 8'h00;

  // comparator mode register fields
  localparam int CDC_MODE_RSVD_BIT = 7;
  localparam int CDC_MODE_RIE_BIT = 5;
  localparam int CDC_MODE_FIE_BIT = 4;
  localparam int CDC_MODE_MD_LSB = 0;
  localparam logic [7:0] CDC_MODE_RESET = 8'h82;
  localparam logic [1:0] CDC_MD_RESET = 2'h2;

  // input codes are millivolts, unsigned
  localparam int CDC_IN_W = 12;

  // hysteresis amounts in millivolts per select code
  localparam logic [CDC_IN_W-1:0] CDC_HYST_L1_MV = 12'h005;
  localparam logic [CDC_IN_W-1:0] CDC_HYST_L2_MV = 12'h00A;
  localparam logic [CDC_IN_W-1:0] CDC_HYST_L3_MV = 12'h014;

  // hysteresis select code to millivolt offset
  function automatic logic [CDC_IN_W:0] cdc_hyst_mv(input logic [1:0] sel);
    logic [CDC_IN_W-1:0] v;
    v = '0;
    case (sel)
      2'h1: v = CDC_HYST_L1_MV;
      2'h2: v = CDC_HYST_L2_MV;
      2'h3: v = CDC_HYST_L3_MV;
      default: v = '0;
    endcase
    return {1'b0, v};
  endfunction

endpackage

//--- pkg/cdc_cmp_if.sv
// bundle between the compare stage and the synchroniser stage
// assumes both stages sit in the same clock domain as the top
`timescale 1ns/1ps
`default_nettype none
interface cdc_cmp_if;
  logic enable;
  logic [1:0] hyp_sel;
  logic [1:0] hyn_sel;
  logic state;
  logic raw;
  logic rise_evt;
  logic fall_evt;

  // compare stage sees settings and the settled state
  modport cmp (input enable, hyp_sel, hyn_sel, state, output raw);
  // synchroniser stage turns raw into state and edge events
  modport syn (input enable, raw, output state, rise_evt, fall_evt);
endinterface
`default_nettype wire

//--- rtl/cdc_compare.sv
// raw compare with programmable hysteresis, no clock on this path
// assumes input codes are digitised millivolts from the analog front
`timescale 1ns/1ps
`default_nettype none
module cdc_compare
  import cdc_pkg::*;
(
  input wire logic [CDC_IN_W-1:0] positive_input, // positive side, mV
  input wire logic [CDC_IN_W-1:0] negative_input, // negative side, mV
  cdc_cmp_if.cmp cmp // settings in, raw out
);

  logic [CDC_IN_W:0] pos_w;
  logic [CDC_IN_W:0] neg_w;
  logic [CDC_IN_W:0] rise_thr;
  logic [CDC_IN_W:0] pos_plus_hyn;
  logic go_high;
  logic stay_high;

  // thresholds widened one bit so sums never wrap
  assign pos_w = {1'b0, positive_input};
  assign neg_w = {1'b0, negative_input};
  assign rise_thr = neg_w + cdc_hyst_mv(cmp.hyp_sel);
  assign pos_plus_hyn = pos_w + cdc_hyst_mv(cmp.hyn_sel);

  // from low, need pos above neg plus positive offset
  assign go_high = pos_w > rise_thr;
  // from high, stay until pos falls below neg minus negative offset
  assign stay_high = !(pos_plus_hyn < neg_w);

  // state is the synchronised result, frozen if the clock stops
  assign cmp.raw = cmp.enable & (cmp.state ? stay_high : go_high);

endmodule
`default_nettype wire

//--- rtl/cdc_sync_edge.sv
// two-stage synchroniser of the raw compare plus edge detection
// assumes raw is asynchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none
module cdc_sync_edge (
  input wire logic clk_sys, // system clock
  input wire logic resetn, // asynchronous reset, active low
  input wire logic clk_en, // freezes state while low
  cdc_cmp_if.syn syn // raw in, latched state and edges out
);

  logic meta_q;
  logic sync_q;
  logic prev_q;
  logic latched;

  // first stage read only by the second
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else if (clk_en) begin
      meta_q <= syn.raw;
      sync_q <= meta_q;
      prev_q <= latched;
    end
  end

  // disabling forces zero at once, not after the pipe drains
  assign latched = sync_q & syn.enable;
  assign syn.state = latched;

  // one-cycle events on transitions of the latched output
  assign syn.rise_evt = clk_en & latched & ~prev_q;
  assign syn.fall_evt = clk_en & ~latched & prev_q;

endmodule
`default_nettype wire

//--- bench/cdc_top_checker.sv
// assertions on the comparator control top ports
// assumes one clock domain; bound to cdc_top from the bench
`timescale 1ns/1ps
`default_nettype none
module cdc_top_checker
  import cdc_pkg::*;
(
  input wire logic clk_sys, // clock
  input wire logic resetn, // reset
  input wire logic clk_en, // run
  input wire logic [CDC_IN_W-1:0] positive_input, // pos
  input wire logic [CDC_IN_W-1:0] negative_input, // neg
  input wire logic [7:0] sfr_addr, // addr
  input wire logic [7:0] sfr_wdata, // wdata
  input wire logic sfr_wr, // write
  input wire logic sfr_rd, // read
  input wire logic [7:0] sfr_rdata, // rdata
  input wire logic irq_source_enable, // src en
  input wire logic irq_global_enable, // glb en
  input wire logic comparator_irq_req, // req
  input wire logic cpu_irq_req, // cpu req
  input wire logic latched_output, // latched
  input wire logic raw_output, // raw
  input wire logic comparator_shutdown, // off
  input wire logic [1:0] response_mode_select, // mode
  input wire logic [1:0] positive_hysteresis_select, // hyp
  input wire logic [1:0] negative_hysteresis_select // hyn
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // taken accesses; clk_en low means nothing is taken
  sequence s_wr(a); sfr_wr && clk_en && sfr_addr == a; endsequence
  sequence s_rd(a); sfr_rd && clk_en && sfr_addr == a; endsequence
  a_off_zero: assert property (
    comparator_shutdown |-> !latched_output && !raw_output)
    else $error("output active while disabled");
  a_enable_bit: assert property (
    s_wr(CDC_ADDR_CTRL) |=> comparator_shutdown == !$past(sfr_wdata[7]))
    else $error("shutdown does not follow enable");
  a_hyst_sel: assert property (
    s_wr(CDC_ADDR_CTRL) |=> {positive_hysteresis_select,
    negative_hysteresis_select} == $past(sfr_wdata[3:0]))
    else $error("hysteresis selects wrong");
  a_mode_sel: assert property (
    s_wr(CDC_ADDR_MODE) |=> response_mode_select == $past(sfr_wdata[1:0]))
    else $error("response mode wrong");
  a_freeze_mode: assert property (
    !clk_en |=> $stable(response_mode_select) && $stable(sfr_rdata))
    else $error("state moved while clock enable low");
  a_out_bit: assert property (
    s_rd(CDC_ADDR_CTRL) |=> sfr_rdata[6] == $past(latched_output))
    else $error("output bit wrong");
  a_rsvd_one: assert property (
    s_rd(CDC_ADDR_MODE) |=> sfr_rdata[7] && !sfr_rdata[6])
    else $error("mode unused bits wrong");
  a_flag_sticky: assert property (
    comparator_irq_req && !(sfr_wr && clk_en) |=> comparator_irq_req)
    else $error("request dropped without write");
  a_irq_gate: assert property (
    cpu_irq_req == (comparator_irq_req && irq_source_enable &&
    irq_global_enable)) else $error("cpu request gating wrong");
  a_sync_lag: assert property (
    $rose(latched_output) |-> $past(raw_output, 2))
    else $error("latched not behind raw");
  a_compare: assert property (
    !comparator_shutdown && positive_hysteresis_select == 2'h0 &&
    negative_hysteresis_select == 2'h0 && positive_input != negative_input
    |-> raw_output == (positive_input > negative_input))
    else $error("raw compare wrong");
endmodule
`default_nettype wire

//--- bench/cdc_cpu_model.sv
// interrupt entry counter standing in for the processor core
// assumes cpu_irq_req is a level request in the clk_sys domain
`timescale 1ns/1ps
`default_nettype none
module cdc_cpu_model (
  input wire logic clk_sys, // clock
  input wire logic resetn, // reset
  input wire logic cpu_irq_req, // gated request
  output logic [7:0] irq_entry_q // handler entries
);
  logic req_q;
  // a held level counts once, like one handler entry
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      req_q <= 1'b0;
      irq_entry_q <= 8'h00;
    end else begin
      req_q <= cpu_irq_req;
      if (cpu_irq_req && !req_q) irq_entry_q <= irq_entry_q + 8'h01;
    end
  end
endmodule
`default_nettype wire

//--- bench/cdc_top_tb.sv
// self-checking bench for the comparator control top
// assumes package, checker and cpu model are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin \
  fail_count++; $display("[ERR] %s exp %h got %h", n, e, a); end end
module cdc_top_tb;
  import cdc_pkg::*;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic clk_en = 1'b1;
  logic [CDC_IN_W-1:0] positive_input = 12'h000;
  logic [CDC_IN_W-1:0] negative_input = 12'h000;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic irq_source_enable = 1'b0;
  logic irq_global_enable = 1'b0;
  logic [7:0] sfr_rdata, irq_entry_q;
  logic comparator_irq_req, cpu_irq_req, latched_output, raw_output;
  logic comparator_shutdown;
  logic [1:0] response_mode_select, positive_hysteresis_select;
  logic [1:0] negative_hysteresis_select;
  int fail_count = 0;
  int check_count = 0;
  cdc_top cdc_top_inst (.clk_sys, .resetn, .clk_en, .positive_input,
    .negative_input, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata,
    .irq_source_enable, .irq_global_enable, .comparator_irq_req,
    .cpu_irq_req, .latched_output, .raw_output, .comparator_shutdown,
    .response_mode_select, .positive_hysteresis_select,
    .negative_hysteresis_select);
  cdc_cpu_model cdc_cpu_model_inst (.clk_sys, .resetn, .cpu_irq_req,
    .irq_entry_q);
  // 200 MHz
  always #2.5 clk_sys = ~clk_sys;
  // wr and rd start and end at a falling edge, step ends at one
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk_sys);
    sfr_wr = 1'b0;
  endtask
  // read data stands from the taken edge and is checked half a cycle later
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk_sys);
    sfr_rd = 1'b0;
    `CHK("sfr_rdata", e, sfr_rdata)
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // raw path has no clock, so settle a moment only
  task automatic setin(input logic [CDC_IN_W-1:0] p,
    input logic [CDC_IN_W-1:0] n);
    positive_input = p;
    negative_input = n;
    #1;
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    logic [CDC_IN_W-1:0] h;
    step(3);
    resetn = 1'b1;
    step(1);
    rd(CDC_ADDR_CTRL, CDC_CTRL_RESET);
    rd(CDC_ADDR_MODE, CDC_MODE_RESET);
    rd(8'h9C, 8'h00);
    `CHK("mode", CDC_MD_RESET, response_mode_select)
    $display("test reset done");
    wr(CDC_ADDR_CTRL, 8'h80);
    setin(12'h064, 12'h032);
    `CHK("raw_output", 1'b1, raw_output)
    step(3);
    rd(CDC_ADDR_CTRL, 8'hE0);
    setin(12'h028, 12'h032);
    step(3);
    rd(CDC_ADDR_CTRL, 8'hB0);
    wr(CDC_ADDR_CTRL, 8'hC0);
    rd(CDC_ADDR_CTRL, 8'h80);
    $display("test compare done");
    wr(CDC_ADDR_MODE, 8'hB0);
    rd(CDC_ADDR_MODE, 8'hB0);
    setin(12'h064, 12'h032);
    step(3);
    `CHK("irq_req", 1'b1, comparator_irq_req)
    `CHK("cpu_irq_req", 1'b0, cpu_irq_req)
    irq_source_enable = 1'b1;
    step(1);
    `CHK("cpu_irq_req", 1'b0, cpu_irq_req)
    irq_global_enable = 1'b1;
    step(2);
    `CHK("cpu_irq_req", 1'b1, cpu_irq_req)
    `CHK("irq_entry_q", 8'h01, irq_entry_q)
    wr(CDC_ADDR_CTRL, 8'h80);
    `CHK("irq_req", 1'b0, comparator_irq_req)
    $display("test interrupt done");
    // codes 0,5,A,F put the same select in both fields
    for (int i = 0; i < 4; i++) begin
      wr(CDC_ADDR_CTRL, 8'h80 | 8'(i * 5));
      `CHK("hyp", 2'(i), positive_hysteresis_select)
      `CHK("hyn", 2'(i), negative_hysteresis_select)
    end
    h = CDC_HYST_L3_MV;
    setin(12'h032 - h, 12'h032);
    `CHK("raw_output", 1'b1, raw_output)
    setin(12'h031 - h, 12'h032);
    `CHK("raw_output", 1'b0, raw_output)
    step(3);
    setin(12'h032 + h, 12'h032);
    `CHK("raw_output", 1'b0, raw_output)
    setin(12'h033 + h, 12'h032);
    `CHK("raw_output", 1'b1, raw_output)
    $display("test hysteresis done");
    for (int m = 0; m < 4; m++) begin
      wr(CDC_ADDR_MODE, 8'hCC | 8'(m));
      rd(CDC_ADDR_MODE, 8'h80 | 8'(m));
      `CHK("mode", 2'(m), response_mode_select)
    end
    // clock enable low: the write must not be taken
    clk_en = 1'b0;
    wr(CDC_ADDR_MODE, 8'h80);
    `CHK("mode", 2'h3, response_mode_select)
    clk_en = 1'b1;
    rd(CDC_ADDR_MODE, 8'h83);
    $display("test mode done");
    // clear lands on the very edge the fall event is taken
    wr(CDC_ADDR_CTRL, 8'h8F);
    setin(12'h000, 12'h032);
    step(2);
    wr(CDC_ADDR_CTRL, 8'h8F);
    rd(CDC_ADDR_CTRL, 8'h9F);
    setin(12'h064, 12'h032);
    step(3);
    $display("test priority done");
    wr(CDC_ADDR_CTRL, 8'h00);
    `CHK("latched_output", 1'b0, latched_output)
    `CHK("raw_output", 1'b0, raw_output)
    `CHK("shutdown", 1'b1, comparator_shutdown)
    step(1);
    rd(CDC_ADDR_CTRL, 8'h10);
    $display("test disable done");
    end_of_test();
  end
endmodule
bind cdc_top cdc_top_checker cdc_top_checker_inst (.clk_sys, .resetn,
  .clk_en, .positive_input, .negative_input, .sfr_addr, .sfr_wdata,
  .sfr_wr, .sfr_rd, .sfr_rdata, .irq_source_enable, .irq_global_enable,
  .comparator_irq_req, .cpu_irq_req, .latched_output, .raw_output,
  .comparator_shutdown, .response_mode_select,
  .positive_hysteresis_select, .negative_hysteresis_select);
`default_nettype wire
